//--- lgx_checker.sv
// assertions on the line-mode control outputs
`timescale 1ns/10ps
module lgx_checker (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  input wire logic PHASE1,
  input wire logic PHASE2,
  input wire logic MODE_TRANSFER,
  input wire logic SUBTRACT,
  input wire logic DELTA_INPUT_SELECT,
  input wire logic [3:0] PHASE,
  input wire logic EXIT
);
  default clocking @(posedge REF_CLK); endclocking
  // a frozen enable holds all state, so those cycles prove nothing
  default disable iff (!RSTN || !CLK_EN);
  sequence s_go;
    PHASE == 4'h0 && MODE_TRANSFER;
  endsequence
  sequence s_done;
    PHASE == 4'h0 && EXIT ##1 !EXIT;
  endsequence
  a_seq_start: assert property (s_go |=> PHASE == 4'h3)
    else $error("no start");
  a_seq_step: assert property (PHASE > 4'h2 && PHASE < 4'hB
    |=> PHASE == $past(PHASE) + 4'h1) else $error("bad step");
  a_seq_exit: assert property (PHASE == 4'hB |=> s_done)
    else $error("bad exit");
  a_sub_set: assert property (PHASE1 |=> SUBTRACT)
    else $error("sub not set");
  a_sub_clear: assert property (PHASE == 4'h6 && !PHASE1
    |=> !SUBTRACT) else $error("sub not cleared");
  a_sub_hold: assert property (SUBTRACT && PHASE != 4'h6
    |=> SUBTRACT) else $error("sub dropped");
  a_sel_clear: assert property (PHASE2 |=> !DELTA_INPUT_SELECT)
    else $error("select not cleared");
  a_sel_set: assert property (PHASE == 4'h4 && !PHASE2
    |=> DELTA_INPUT_SELECT) else $error("select not set");
endmodule
bind lgx_datapath lgx_checker chk (.REF_CLK, .RSTN, .CLK_EN, .PHASE1,
  .PHASE2, .MODE_TRANSFER, .SUBTRACT, .DELTA_INPUT_SELECT, .PHASE, .EXIT);

//--- lgx_datapath.sv
// x/y position registers, line generator datapath and line-mode sequencer
`timescale 1ns/10ps
module lgx_datapath #(
  parameter int W = lgx_pkg::POS_W
) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  input wire logic [W-1:0] X_SWITCH,
  input wire logic [W-1:0] DATA_REG,
  input wire logic POS_LOAD_X,
  input wire logic POS_LOAD_Y,
  input wire logic POS_COUNT_X,
  input wire logic POS_COUNT_Y,
  input wire logic LSB_SET_FORWARD_X,
  input wire logic LSB_SET_FORWARD_Y,
  input wire logic LSB_CLEAR_BACKWARD_X,
  input wire logic LSB_CLEAR_BACKWARD_Y,
  input wire logic LSB_INVERT_X,
  input wire logic LSB_INVERT_Y,
  input wire logic DIR_LOAD_X,
  input wire logic DIR_LOAD_Y,
  input wire logic DELTA_STROBE_X,
  input wire logic DELTA_STROBE_Y,
  input wire logic ACCUM_REG_STROBE_X,
  input wire logic ACCUM_REG_STROBE_Y,
  input wire logic ACCUM_ZERO_FORCE_X,
  input wire logic ACCUM_ZERO_FORCE_Y,
  input wire logic PHASE1,
  input wire logic PHASE2,
  input wire logic MODE_TRANSFER,
  output logic [W-1:0] X_POS,
  output logic [W-1:0] Y_POS,
  output logic X_DIR,
  output logic Y_DIR,
  output logic [W-1:0] X_DELTA,
  output logic [W-1:0] Y_DELTA,
  output logic [W-1:0] X_ACCUM,
  output logic [W-1:0] Y_ACCUM,
  output logic SUBTRACT,
  output logic DELTA_INPUT_SELECT,
  output logic [3:0] PHASE,
  output logic EXIT
);
  // -------------------------------------------------------------
  // mode-1 control flops
  // -------------------------------------------------------------
  logic sub_r, sub_nxt;
  logic sel_r, sel_nxt;
  lgx_pkg::lgx_state_t st_r, st_nxt;
  logic exit_r, exit_nxt;
  logic [3:0] ph_r, ph_nxt;

  always_comb begin
    sub_nxt = sub_r;
    sel_nxt = sel_r;
    if (PHASE1) begin
      sub_nxt = 1'b1;
    end else if (st_r == lgx_pkg::LGX_T6) begin
      sub_nxt = 1'b0;
    end
    if (PHASE2) begin
      sel_nxt = 1'b0;
    end else if (st_r == lgx_pkg::LGX_T4) begin
      sel_nxt = 1'b1;
    end
  end

  // -------------------------------------------------------------
  // line-mode sequencer, one phase per enabled clock
  // -------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    exit_nxt = 1'b0;
    unique case (st_r)
      lgx_pkg::LGX_IDLE: begin
        if (MODE_TRANSFER) begin
          st_nxt = lgx_pkg::LGX_T3;
        end
      end
      lgx_pkg::LGX_T3: st_nxt = lgx_pkg::LGX_T4;
      lgx_pkg::LGX_T4: st_nxt = lgx_pkg::LGX_T5;
      lgx_pkg::LGX_T5: st_nxt = lgx_pkg::LGX_T6;
      lgx_pkg::LGX_T6: st_nxt = lgx_pkg::LGX_T7;
      lgx_pkg::LGX_T7: st_nxt = lgx_pkg::LGX_T8;
      lgx_pkg::LGX_T8: st_nxt = lgx_pkg::LGX_T9;
      lgx_pkg::LGX_T9: st_nxt = lgx_pkg::LGX_T10;
      lgx_pkg::LGX_T10: st_nxt = lgx_pkg::LGX_T11;
      lgx_pkg::LGX_T11: begin
        st_nxt = lgx_pkg::LGX_IDLE;
        exit_nxt = 1'b1;
      end
      default: st_nxt = lgx_pkg::LGX_IDLE;
    endcase
    unique case (st_nxt)
      lgx_pkg::LGX_T3: ph_nxt = lgx_pkg::PH_FIRST;
      lgx_pkg::LGX_T4: ph_nxt = 4'h4;
      lgx_pkg::LGX_T5: ph_nxt = 4'h5;
      lgx_pkg::LGX_T6: ph_nxt = 4'h6;
      lgx_pkg::LGX_T7: ph_nxt = 4'h7;
      lgx_pkg::LGX_T8: ph_nxt = 4'h8;
      lgx_pkg::LGX_T9: ph_nxt = 4'h9;
      lgx_pkg::LGX_T10: ph_nxt = 4'hA;
      lgx_pkg::LGX_T11: ph_nxt = lgx_pkg::PH_LAST;
      default: ph_nxt = 4'h0;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sub_r <= 1'b0;
      sel_r <= 1'b1;
      st_r <= lgx_pkg::LGX_IDLE;
      exit_r <= 1'b0;
      ph_r <= 4'h0;
    end else if (CLK_EN) begin
      sub_r <= sub_nxt;
      sel_r <= sel_nxt;
      st_r <= st_nxt;
      exit_r <= exit_nxt;
      ph_r <= ph_nxt;
    end
  end

  assign SUBTRACT = sub_r;
  assign DELTA_INPUT_SELECT = sel_r;
  assign PHASE = ph_r;
  assign EXIT = exit_r;

  // -------------------------------------------------------------
  // per-axis datapath, index 0 is x and 1 is y
  // -------------------------------------------------------------
  logic [W-1:0] pos_r [2], pos_nxt [2];
  logic [W-1:0] dlt_r [2], dlt_nxt [2];
  logic [W-1:0] acc_r [2], acc_nxt [2];
  logic dir_r [2], dir_nxt [2];
  logic [W-1:0] sum [2];
  logic [W-1:0] pos_src [2];
  logic ld [2], cnt [2], setf [2], clrb [2], inv [2], dld [2];
  logic dstb [2], astb [2], zf [2];

  assign pos_src[0] = X_SWITCH;
  assign pos_src[1] = DATA_REG;
  assign ld = '{POS_LOAD_X, POS_LOAD_Y};
  assign cnt = '{POS_COUNT_X, POS_COUNT_Y};
  assign setf = '{LSB_SET_FORWARD_X, LSB_SET_FORWARD_Y};
  assign clrb = '{LSB_CLEAR_BACKWARD_X, LSB_CLEAR_BACKWARD_Y};
  assign inv = '{LSB_INVERT_X, LSB_INVERT_Y};
  assign dld = '{DIR_LOAD_X, DIR_LOAD_Y};
  assign dstb = '{DELTA_STROBE_X, DELTA_STROBE_Y};
  assign astb = '{ACCUM_REG_STROBE_X, ACCUM_REG_STROBE_Y};
  assign zf = '{ACCUM_ZERO_FORCE_X, ACCUM_ZERO_FORCE_Y};

  // complement gate ahead of the adder
  function automatic logic [W-1:0] gate_in(input logic [W-1:0] d,
                                           input logic s);
    gate_in = s ? ~d : d;
  endfunction

  for (genvar a = 0; a < 2; a++) begin : g_axis
    logic [W-2:0] low_sum;
    logic low_co;
    logic [W-1:0] gd;
    assign gd = gate_in(dlt_r[a], sub_r);
    // low slice adder; msb slice adds its own bit plus the carry
    assign {low_co, low_sum} = {1'b0, gd[W-2:0]} +
                               {1'b0, acc_r[a][W-2:0]};
    assign sum[a] = {gd[W-1] ^ acc_r[a][W-1] ^ low_co,
                     low_sum};

    always_comb begin
      pos_nxt[a] = pos_r[a];
      dlt_nxt[a] = dlt_r[a];
      acc_nxt[a] = acc_r[a];
      dir_nxt[a] = dir_r[a];
      if (ld[a]) begin
        pos_nxt[a] = pos_src[a];
      end else begin
        if (cnt[a]) begin
          // lsb flop counts alongside the upper bits
          pos_nxt[a] = dir_r[a] ? pos_r[a] + 1'b1
                                : pos_r[a] - 1'b1;
        end
        if (setf[a]) begin
          pos_nxt[a][0] = 1'b1;
        end else if (clrb[a]) begin
          pos_nxt[a][0] = 1'b0;
        end else if (inv[a]) begin
          pos_nxt[a][0] = ~pos_r[a][0];
        end
      end
      if (dstb[a]) begin
        if (sub_r) begin
          dlt_nxt[a] = sel_r ? pos_r[a] : sum[a];
        end else begin
          dlt_nxt[a] = {dlt_r[a][W-2:0], 1'b0};
        end
      end
      if (astb[a]) begin
        if (sub_r && zf[a]) begin
          acc_nxt[a] = '0;
        end else if (sub_r) begin
          acc_nxt[a] = DATA_REG;
        end else begin
          acc_nxt[a] = sum[a];
        end
      end
      if (dld[a]) begin
        // sign of the msb slice sum steers the direction
        dir_nxt[a] = ~sum[a][W-1];
      end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
        pos_r[a] <= lgx_pkg::POS_RST;
        dlt_r[a] <= lgx_pkg::DELTA_RST;
        acc_r[a] <= lgx_pkg::ACC_RST;
        dir_r[a] <= 1'b1;
      end else if (CLK_EN) begin
        pos_r[a] <= pos_nxt[a];
        dlt_r[a] <= dlt_nxt[a];
        acc_r[a] <= acc_nxt[a];
        dir_r[a] <= dir_nxt[a];
      end
    end
  end

  assign X_POS = pos_r[0];
  assign Y_POS = pos_r[1];
  assign X_DIR = dir_r[0];
  assign Y_DIR = dir_r[1];
  assign X_DELTA = dlt_r[0];
  assign Y_DELTA = dlt_r[1];
  assign X_ACCUM = acc_r[0];
  assign Y_ACCUM = acc_r[1];
endmodule

//--- lgx_datapath_bench.sv
// self-checking bench for the line generator datapath
`timescale 1ns/10ps
module lgx_datapath_bench;
  logic clk, rstn, en, xdir, ydir, sub, sel, ph1, ph2, mt, ex;
  logic [10:0] st;
  logic [8:0] xs, dr, xp, yp, xd, xa, yd, ya;
  logic [3:0] ph;
  int mismatches, cmp_count, i;
  lgx_partner ptn (.clk(clk), .start(st[10]), .phase1(ph1), .phase2(ph2),
    .mode_transfer(mt));
  // y strobes mirror x except the load, so both axes run every path but the y lsb set-forward, which the y load masks
  lgx_datapath dut (.REF_CLK(clk), .RSTN(rstn), .CLK_EN(en),
    .X_SWITCH(xs), .DATA_REG(dr), .POS_LOAD_X(st[0]), .POS_LOAD_Y(st[1]),
    .POS_COUNT_X(st[2]), .POS_COUNT_Y(st[2]), .DIR_LOAD_X(st[6]),
    .LSB_SET_FORWARD_X(st[3]), .LSB_SET_FORWARD_Y(st[3]),
    .LSB_CLEAR_BACKWARD_X(st[4]), .LSB_CLEAR_BACKWARD_Y(st[4]),
    .LSB_INVERT_X(st[5]), .LSB_INVERT_Y(st[5]), .DIR_LOAD_Y(st[6]),
    .DELTA_STROBE_X(st[7]), .DELTA_STROBE_Y(st[7]), .X_POS(xp),
    .ACCUM_REG_STROBE_X(st[8]), .ACCUM_REG_STROBE_Y(st[8]),
    .ACCUM_ZERO_FORCE_X(st[9]), .ACCUM_ZERO_FORCE_Y(st[9]), .Y_POS(yp),
    .PHASE1(ph1), .PHASE2(ph2), .MODE_TRANSFER(mt), .X_DIR(xdir),
    .Y_DIR(ydir), .X_DELTA(xd), .Y_DELTA(yd), .X_ACCUM(xa), .Y_ACCUM(ya),
    .SUBTRACT(sub), .DELTA_INPUT_SELECT(sel), .PHASE(ph), .EXIT(ex));
  task chk(input string n, input logic [17:0] s, e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // one strobe cycle, then a quiet cycle so no edge sees two changes
  task t(input logic [10:0] s);
    st = s;
    @(negedge clk);
    st = 11'h000;
    @(negedge clk);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (500) @(negedge clk);
    mismatches++;
    close_out;
  end
  initial begin
    {rstn, en, st} = 13'h0000;
    xs = 9'h005;
    dr = 9'h1FF;
    repeat (20) @(negedge clk);
    {rstn, en} = 2'h3;
    chk("reset", {xp, 5'h00, xdir, sel, sub, ex}, 18'h0000C);
    t(11'h001);
    t(11'h004);
    chk("x_up", {xp, yp}, {9'h006, 9'h001});
    t(11'h00A);
    chk("y_load", {xp, yp}, {9'h007, 9'h1FF});
    t(11'h004);
    chk("wrap", {xp, yp}, {9'h008, 9'h000});
    t(11'h020);
    chk("lsb_inv", {xp, yp}, {9'h009, 9'h001});
    t(11'h010);
    chk("lsb_clr", {xp, yp}, {9'h008, 9'h000});
    t(11'h400);
    t(11'h180);
    chk("delta_pos", {xd, xa}, {9'h008, 9'h1FF});
    chk("y_delta_pos", {yd, ya}, {9'h000, 9'h1FF});
    t(11'h3C0);
    chk("delta_sum", {xd, xa}, {9'h1F6, 9'h000});
    chk("dir_sel", {xdir, sel, 12'h000, ph}, 18'h10005);
    chk("y_delta_sum", {yd, ya}, {9'h1FE, 9'h000});
    chk("y_dir", {17'h00000, ydir}, 18'h00000);
    t(11'h004);
    chk("x_down", {8'h00, sub, xp}, 18'h00007);
    chk("y_down", {9'h000, yp}, {9'h000, 9'h1FF});
    t(11'h080);
    t(11'h100);
    chk("shift_add", {xd, xa}, {9'h1EC, 9'h1EC});
    chk("y_shift_add", {yd, ya}, {9'h1FC, 9'h1FC});
    for (i = 0; i < 9 && ex !== 1'b1; i++)
      @(negedge clk);
    chk("exit", {13'h0000, ex, ph}, 18'h00010);
    // a count with the enable low must leave both positions alone
    en = 1'b0;
    t(11'h004);
    chk("frozen", {xp, yp}, {9'h007, 9'h1FF});
    en = 1'b1;
    rstn = 1'b0;
    @(negedge clk);
    rstn = 1'b1;
    chk("reset2", {xp, yp}, {9'h000, 9'h000});
    close_out;
  end
endmodule

//--- lgx_partner.sv
// timing model that issues phase one, phase two and the transfer
`timescale 1ns/10ps
module lgx_partner (
  input wire logic clk,
  input wire logic start,
  output logic phase1 = 1'b0,
  output logic phase2 = 1'b0,
  output logic mode_transfer = 1'b0
);
  logic armed;
  always @(posedge clk) armed <= start;
  // each pulse lasts one cycle, then the line falls back low
  always @(negedge clk) begin
    phase1 <= armed;
    phase2 <= phase1;
    mode_transfer <= phase2;
  end
endmodule

//--- lgx_pkg.sv
// constants for the line generator xy datapath
package lgx_pkg;
  localparam int POS_W = 9;
  localparam int LOW_W = 8;
  localparam logic [8:0] POS_RST = 9'h000;
  localparam logic [8:0] DELTA_RST = 9'h000;
  localparam logic [8:0] ACC_RST = 9'h000;
  localparam logic [3:0] PH_FIRST = 4'h3;
  localparam logic [3:0] PH_LAST = 4'hB;
  typedef enum logic [3:0] {
    LGX_IDLE = 4'h0,
    LGX_T3 = 4'h1,
    LGX_T4 = 4'h3,
    LGX_T5 = 4'h2,
    LGX_T6 = 4'h6,
    LGX_T7 = 4'h7,
    LGX_T8 = 4'h5,
    LGX_T9 = 4'h4,
    LGX_T10 = 4'hC,
    LGX_T11 = 4'hD
  } lgx_state_t;
endpackage
